// ==== common/pcs_regs.svh ====
// Purpose: Register map constants for the transceiver control/status bank
// Assumes: 5-bit register index, 16-bit data
// Notes: Control register offset is chosen locally
`ifndef PCS_REGS_SVH
`define PCS_REGS_SVH

`define PCS_ADDR_W 5
`define PCS_DATA_W 16
`define PCS_CTRL_ADDR 5'h10
`define PCS_STAT_ADDR 5'h11

// Control register fields
`define PCS_CTRL_PSM_HI 9
`define PCS_CTRL_PSM_LO 8
`define PCS_CTRL_XOVER_HI 6
`define PCS_CTRL_XOVER_LO 5
`define PCS_CTRL_CLKDIS 4
`define PCS_CTRL_RSVD 3
`define PCS_CTRL_STANDBY 2
`define PCS_CTRL_TXINV 1
`define PCS_CTRL_JABDIS 0
`define PCS_CTRL_WMASK 16'h0377
`define PCS_CTRL_RST 16'h0048

// Status register fields
`define PCS_STAT_PAGE 12
`define PCS_STAT_POL10_RST 1'h1

`define PCS_PSM_IEEE 2'h1
`define PCS_XOVER_MDIX 2'h1
`define PCS_XOVER_MDI 2'h0

`endif

// ==== common/pcs_pkg.sv ====
// Purpose: Types for the transceiver control/status bank
// Assumes: Nothing
// Notes: Crossover decode result
package pcs_pkg;
	typedef enum logic [2:0] {
		PCS_XO_MDI = 3'h1,
		PCS_XO_MDIX = 3'h2,
		PCS_XO_AUTO = 3'h4
	} pcs_xover_t;
endpackage

// ==== hw/pcs_ctrl_stat.sv ====
// Purpose: Control and status registers of an Ethernet transceiver
// Assumes: Status inputs come from logic on mclk_i
// Notes: Read data valid the cycle after the read strobe
// Summary of operation
// - Decode crossover field: auto, MDI-X or MDI
// - Control bit 4 stops 125 MHz clock
// - IEEE power mode with clock on: PLL down
// - Control bit 3 reads one, writes ignored
// - Standby keeps power but blocks link
// - Control bit 1 inverts line drivers
// - Control bit 0 disables jabber detection
// - Status 15:14 report operating speed
// - Status 13 reports full duplex
// - Page received latches, cleared by read
// - Status 11 shows negotiation resolved
// - Status 10 shows link up
// - Status 9:8 show pair crossover resolution
// - Status 7 shows speed optimisation active
// - Status 6 shows sleep mode
// - Status 5:2 show channel polarity reversal
// - Status 1 shows 10M polarity, resets one
// - Status 0 mirrors jabber, not read-cleared
//
// Strobed register access was chosen for this implementation.
`timescale 1ns/1ps
`include "pcs_regs.svh"

module pcs_ctrl_stat (
	input wire logic mclk_i,
	input wire logic rst_i,
	input wire logic [4:0] addr_i,
	input wire logic [15:0] wdata_i,
	input wire logic wr_i,
	input wire logic rd_i,
	output logic [15:0] rdata_o,
	input wire logic [1:0] speed_state_i,
	input wire logic full_duplex_i,
	input wire logic page_rx_i,
	input wire logic an_resolved_i,
	input wire logic link_up_i,
	input wire logic pair_cd_crossed_i,
	input wire logic pair_ab_crossed_i,
	input wire logic downshift_active_i,
	input wire logic sleep_i,
	input wire logic [3:0] channel_polarity_reversed_i,
	input wire logic pol10_ok_i,
	input wire logic jabber_i,
	output pcs_pkg::pcs_xover_t crossover_select_o,
	output logic clock_125_output_en_o,
	output logic pll_power_down_o,
	output logic standby_o,
	output logic link_block_o,
	output logic tx_invert_en_o,
	output logic jabber_detect_en_o
);

	logic [15:0] ctrl_q;
	logic page_q;
	logic pol10_q;
	logic [15:0] stat_w;
	logic stat_rd;

	// ------------------------------------------------------------
	// Control register
	// ------------------------------------------------------------
	always_ff @(posedge mclk_i) begin
		if (rst_i) begin
			ctrl_q <= `PCS_CTRL_RST;
		end else if (wr_i && addr_i == `PCS_CTRL_ADDR) begin
			ctrl_q <= (wdata_i & `PCS_CTRL_WMASK)
				| (16'h1 << `PCS_CTRL_RSVD);
		end
	end

	// ------------------------------------------------------------
	// Control outputs
	// ------------------------------------------------------------
	always_comb begin
		logic [1:0] xo;
		xo = ctrl_q[`PCS_CTRL_XOVER_HI:`PCS_CTRL_XOVER_LO];
		if (xo[1]) begin
			crossover_select_o = pcs_pkg::PCS_XO_AUTO;
		end else if (xo == `PCS_XOVER_MDIX) begin
			crossover_select_o = pcs_pkg::PCS_XO_MDIX;
		end else begin
			crossover_select_o = pcs_pkg::PCS_XO_MDI;
		end
	end

	assign clock_125_output_en_o = ~ctrl_q[`PCS_CTRL_CLKDIS];
	assign pll_power_down_o =
		(ctrl_q[`PCS_CTRL_PSM_HI:`PCS_CTRL_PSM_LO] == `PCS_PSM_IEEE)
		&& !ctrl_q[`PCS_CTRL_CLKDIS];
	assign standby_o = ctrl_q[`PCS_CTRL_STANDBY];
	assign link_block_o = ctrl_q[`PCS_CTRL_STANDBY];
	assign tx_invert_en_o = ctrl_q[`PCS_CTRL_TXINV];
	assign jabber_detect_en_o = ~ctrl_q[`PCS_CTRL_JABDIS];

	// ------------------------------------------------------------
	// Status latches
	// ------------------------------------------------------------
	assign stat_rd = rd_i && addr_i == `PCS_STAT_ADDR;

	always_ff @(posedge mclk_i) begin
		if (rst_i) begin
			page_q <= 1'h0;
		end else if (page_rx_i) begin
			page_q <= 1'h1;
		end else if (stat_rd) begin
			page_q <= 1'h0;
		end
	end

	// Polarity flop gives the documented reset value of one
	always_ff @(posedge mclk_i) begin
		if (rst_i) begin
			pol10_q <= `PCS_STAT_POL10_RST;
		end else begin
			pol10_q <= pol10_ok_i;
		end
	end

	// Status image; writes never reach it
	assign stat_w = {speed_state_i,
		full_duplex_i,
		page_q,
		an_resolved_i,
		link_up_i,
		pair_cd_crossed_i, pair_ab_crossed_i,
		downshift_active_i,
		sleep_i,
		channel_polarity_reversed_i,
		pol10_q,
		jabber_i};

	// ------------------------------------------------------------
	// Read port
	// ------------------------------------------------------------
	always_ff @(posedge mclk_i) begin
		if (rst_i) begin
			rdata_o <= 16'h0000;
		end else if (rd_i) begin
			if (addr_i == `PCS_CTRL_ADDR) begin
				rdata_o <= ctrl_q;
			end else if (addr_i == `PCS_STAT_ADDR) begin
				rdata_o <= stat_w;
			end else begin
				rdata_o <= 16'h0000;
			end
		end else begin
			rdata_o <= 16'h0000;
		end
	end

endmodule

// ==== tb/pcs_ctrl_stat_props.sv ====
// Purpose: Port assertions for the control/status bank
// Assumes: Control at index 10h, status at 11h
// Notes: Bound to the design top
`timescale 1ns/1ps
module pcs_ctrl_stat_props (
	input wire logic mclk_i, rst_i, wr_i, rd_i, page_rx_i, jabber_i,
	input wire logic [4:0] addr_i,
	input wire logic [15:0] wdata_i, rdata_o,
	input wire pcs_pkg::pcs_xover_t crossover_select_o,
	input wire logic clock_125_output_en_o, pll_power_down_o, standby_o,
	input wire logic link_block_o, tx_invert_en_o, jabber_detect_en_o
);
	default clocking @(posedge mclk_i); endclocking
	default disable iff (rst_i);
	wire cw = wr_i && addr_i == 5'h10;
	wire sr = rd_i && addr_i == 5'h11;
	xover_decode_a: assert property (cw |=> crossover_select_o ==
		($past(wdata_i[6]) ? 3'h4 : $past(wdata_i[5]) ? 3'h2 : 3'h1))
		else $error("xover");
	clk_gate_a: assert property (cw |=>
		clock_125_output_en_o != $past(wdata_i[4])) else $error("clk");
	pll_down_a: assert property (cw |=> pll_power_down_o ==
		($past(wdata_i[9:8]) == 2'h1 && !$past(wdata_i[4]))) else $error("pll");
	rsvd_one_a: assert property (rd_i && addr_i == 5'h10 |=>
		rdata_o[3]) else $error("rsvd");
	standby_block_a: assert property (cw |=> standby_o ==
		$past(wdata_i[2]) && link_block_o == standby_o) else $error("stby");
	tx_invert_a: assert property (cw |=>
		tx_invert_en_o == $past(wdata_i[1])) else $error("inv");
	jabber_en_a: assert property (cw |=>
		jabber_detect_en_o != $past(wdata_i[0])) else $error("jab en");
	page_latch_a: assert property (page_rx_i ##1 sr |=>
		rdata_o[12]) else $error("page");
	jabber_copy_a: assert property (sr |=>
		rdata_o[0] == $past(jabber_i)) else $error("jab");
endmodule
bind pcs_ctrl_stat pcs_ctrl_stat_props i_pcs_ctrl_stat_props (.*);

// ==== tb/pcs_ctrl_stat_tb.sv ====
// Purpose: Self-checking bench for the control/status bank
// Assumes: Status inputs steady around reads
// Notes: Control outputs packed as xover,clk,pll,stby,blk,inv,jab
`timescale 1ns/1ps
module pcs_ctrl_stat_tb;
	logic mclk_i = 0, rst_i = 1, wr_i = 0, rd_i = 0, full_duplex_i = 0;
	logic page_rx_i = 0, an_resolved_i = 0, link_up_i = 0, sleep_i = 0;
	logic pair_cd_crossed_i = 0, pair_ab_crossed_i = 0, jabber_i = 0;
	logic downshift_active_i = 0, pol10_ok_i = 1;
	logic [1:0] speed_state_i = 0;
	logic [3:0] channel_polarity_reversed_i = 0;
	logic [4:0] addr_i = 0;
	logic [15:0] wdata_i = 0, rdata_o;
	logic clock_125_output_en_o, pll_power_down_o, standby_o;
	logic link_block_o, tx_invert_en_o, jabber_detect_en_o;
	pcs_pkg::pcs_xover_t crossover_select_o;
	int num_errors = 0, check_count = 0;
	always #2.5 mclk_i = ~mclk_i;
	pcs_ctrl_stat i_pcs_ctrl_stat (.*);
	task chk(string n, logic [15:0] s, e);
		check_count++;
		if (s !== e) begin
			num_errors++;
			$display("[FAIL] %s exp %h got %h", n, e, s);
		end
	endtask
	task wr(logic [4:0] a, logic [15:0] d);
		@(posedge mclk_i);
		addr_i <= a;
		wdata_i <= d;
		wr_i <= 1'h1;
		@(posedge mclk_i);
		wr_i <= 1'h0;
	endtask
	task rd(logic [4:0] a, logic [15:0] e);
		@(posedge mclk_i);
		addr_i <= a;
		rd_i <= 1'h1;
		@(posedge mclk_i);
		rd_i <= 1'h0;
		#1 chk("rdata", rdata_o, e);
	endtask
	task ctl(logic [8:0] e);
		#1 chk("ctl", {crossover_select_o, clock_125_output_en_o,
			pll_power_down_o, standby_o, link_block_o, tx_invert_en_o,
			jabber_detect_en_o}, e);
	endtask
	task cw(logic [15:0] d, r, logic [8:0] c);
		wr(5'h10, d);
		ctl(c);
		rd(5'h10, r);
	endtask
	task tally_and_finish;
		$display("checks %0d mismatches %0d", check_count, num_errors);
		if (num_errors == 0 && check_count > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	initial begin
		repeat (6) @(posedge mclk_i);
		rst_i <= 1'h0;
		ctl(9'h121);
		rd(5'h10, 16'h0048);
		rd(5'h11, 16'h0002);
		$display("reset test done");
		cw(16'hFFFF, 16'h037F, 9'h10E);
		cw(16'h0100, 16'h0108, 9'h071);
		cw(16'h0020, 16'h0028, 9'h0A1);
		cw(16'h0051, 16'h0059, 9'h100);
		$display("control test done");
		@(posedge mclk_i);
		{speed_state_i, full_duplex_i, an_resolved_i, link_up_i,
			pair_cd_crossed_i, pair_ab_crossed_i, downshift_active_i,
			sleep_i, channel_polarity_reversed_i, jabber_i}
			<= 14'h2EB5;
		wr(5'h11, 16'hFFFF);
		rd(5'h11, 16'hAD6B);
		@(posedge mclk_i);
		page_rx_i <= 1'h1;
		@(posedge mclk_i);
		page_rx_i <= 1'h0;
		rd(5'h11, 16'hBD6B);
		rd(5'h11, 16'hAD6B);
		@(posedge mclk_i);
		pol10_ok_i <= 1'h0;
		rd(5'h11, 16'hAD69);
		// Inverse pattern: every remaining status bit also seen high
		@(posedge mclk_i);
		{speed_state_i, full_duplex_i, an_resolved_i, link_up_i,
			pair_cd_crossed_i, pair_ab_crossed_i, downshift_active_i,
			sleep_i, channel_polarity_reversed_i, jabber_i}
			<= 14'h114A;
		rd(5'h11, 16'h4294);
		// Page event in the same cycle as a status read: set wins
		@(posedge mclk_i);
		addr_i <= 5'h11;
		rd_i <= 1'h1;
		page_rx_i <= 1'h1;
		@(posedge mclk_i);
		rd_i <= 1'h0;
		page_rx_i <= 1'h0;
		#1 chk("rdata", rdata_o, 16'h4294);
		rd(5'h11, 16'h5294);
		rd(5'h11, 16'h4294);
		rd(5'h00, 16'h0000);
		$display("status test done");
		tally_and_finish;
	end
endmodule
